// >>> flp_map.svh
// offsets, field positions, reset values and counts of the flash write-protection block
// assumes inclusion by bare name from the design files; definitions only
//
// What this block does
// - status write refused when disable bit set, pin low
// - writes need write-enable latch, else ignored
// - sector protected by level OR per-sector scheme
// - persistent or dynamic bit 0 blocks group
// - persistent bits frozen while lock is 0
// - persistent bits start erased, sectors unprotected
// - persistent mode: lock set at reset
// - lock-clear drives lock 0 until reset
// - password mode: lock cleared at reset
// - 64-bit password exact match sets lock
// - after lock-clear, unlock refused until reset
// - one-time bits select persistent or password mode
// - 286 groups: 32 small sectors plus 254 blocks
// - groups 0-31 small sectors, then per block
// - dynamic write/read uses 00h protect, FFh unprotect
// - persistent bits programmed singly, erased all together
`ifndef FLP_MAP_SVH
`define FLP_MAP_SVH

`define FLP_OFF_CMD      8'h00
`define FLP_OFF_ADDR     8'h04
`define FLP_OFF_DATA     8'h08
`define FLP_OFF_PWD_LO   8'h0C
`define FLP_OFF_PWD_HI   8'h10
`define FLP_OFF_STATUS   8'h14
`define FLP_OFF_PROT     8'h18

`define FLP_GROUPS       286
`define FLP_SMALL_GROUPS 32
`define FLP_BIG_BLOCKS   254
`define FLP_SMALL_END    24'h01FFFF
`define FLP_FIRST_BLOCK  2

`define FLP_BYTE_PROT    8'h00
`define FLP_BYTE_UNPROT  8'hFF
`define FLP_PWD_RST      64'hFFFF_FFFF_FFFF_FFFF
`define FLP_LOCK_RST     1'b1
`define FLP_DYB_RST      1'b1
`define FLP_PPB_RST      1'b1

`define FLP_SR_WEL       1
`define FLP_SR_BP_LSB    2
`define FLP_SR_QE        6
`define FLP_SR_STATUS_WRITE_DISABLE      7
`define FLP_ST_LOCK      8
`define FLP_ST_PWDMODE   9
`define FLP_ST_UNLKDIS   10
`define FLP_ST_REFUSED   11
`define FLP_ST_WP        12
`define FLP_PR_PPB_LSB   8
`define FLP_PR_GRP_PROT  16

`endif

// >>> flp_pkg.sv
// types of the flash write-protection block
// assumes nothing beyond a SystemVerilog compiler
package flp_pkg;

    typedef enum logic [3:0] {
        FLP_OP_NOP    = 4'h0,
        FLP_OP_WRITE_ENABLE_COMMAND   = 4'h1,
        FLP_OP_WRDI   = 4'h2,
        FLP_OP_WRSR   = 4'h3,
        FLP_OP_PROG   = 4'h4,
        FLP_OP_ERASE  = 4'h5,
        FLP_OP_PGPPB  = 4'h6,
        FLP_OP_ERPPB  = 4'h7,
        FLP_OP_WRDYB  = 4'h8,
        FLP_OP_CLRLK  = 4'h9,
        FLP_OP_UNLOCK = 4'hA,
        FLP_OP_PGPWD  = 4'hB,
        FLP_OP_PWDSEL = 4'hC
    } flp_op_t;

endpackage

// >>> flp_group_map.sv
// address to protection group translation, small sectors at the bottom
// assumes a 24-bit byte address of the main array
`timescale 1ns/1ps
`include "flp_map.svh"

module flp_group_map
    import flp_pkg::*;
(
    input  wire logic [23:0] addr,      // array byte address
    output logic      [8:0]  group      // protection group index
);

    always_comb
    begin
        if (addr <= `FLP_SMALL_END)
        begin
            group = {4'h0, addr[16:12]};
        end
        else
        begin
            group = 9'(`FLP_SMALL_GROUPS) + {1'b0, addr[23:16]}
                    - 9'(`FLP_FIRST_BLOCK);
        end
    end

endmodule // flp_group_map

// >>> flp_top.sv
// protection decision logic of a serial flash, reached over APB
// assumes pins wp_n, hw_rst_n and vcc_low are asynchronous to pclk
`timescale 1ns/1ps
`include "flp_map.svh"

module flp_top
    import flp_pkg::*;
#(
    parameter int GROUPS = `FLP_GROUPS,
    parameter int SMALL  = `FLP_SMALL_GROUPS
)
(
    input  wire logic        pclk,          // bus clock
    input  wire logic        presetn,       // power-on reset, low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    input  wire logic        wp_n,          // write-protect pin
    input  wire logic        hw_rst_n,      // hardware reset pin
    input  wire logic        vcc_low,       // supply below inhibit level
    output logic             prog_grant,    // array write allowed pulse
    output logic             prog_reject,   // array write refused pulse
    output logic             lock_out       // persistent-bits lock
);

    generate
        if (GROUPS != SMALL + `FLP_BIG_BLOCKS || GROUPS > 511 || SMALL != 32)
        begin : g_bad
            $error("flp_top: unsupported group layout");
        end
    endgenerate

    // pin synchronisers: bit0 wp_n, bit1 hw_rst_n, bit2 vcc_low
    logic [2:0]  sync1_q;
    logic [2:0]  sync2_q;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [23:0] addr_q;
    logic [7:0]  data_q;
    logic [63:0] pwd_in_q;
    flp_op_t     op_q;
    logic        go_q;
    logic        wel_q;
    logic [3:0]  bp_q;
    logic        qe_q;
    logic        status_write_disable_q;
    logic [GROUPS-1:0] dyb_q;
    logic [GROUPS-1:0] ppb_q;
    logic        lock_q;
    logic        unlk_dis_q;
    logic        pwd_mode_q;
    logic [63:0] pwd_q;
    logic        refused_q;
    logic        grant_q;
    logic        reject_q;

    logic        wp_high;
    logic        hw_rst;
    logic        inhibit;
    logic        acc;
    logic        done;
    logic        accept;
    logic        ok;
    logic [8:0]  grp;
    logic        grp_prot;
    logic [7:0]  sreg;

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign prog_grant  = grant_q;
    assign prog_reject = reject_q;
    assign lock_out    = lock_q;

    function automatic logic needs_wel(input flp_op_t op);
        needs_wel = !(op inside {FLP_OP_NOP, FLP_OP_WRITE_ENABLE_COMMAND, FLP_OP_WRDI, FLP_OP_UNLOCK});
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a inside {`FLP_OFF_CMD, `FLP_OFF_ADDR, `FLP_OFF_DATA,
                            `FLP_OFF_PWD_LO, `FLP_OFF_PWD_HI,
                            `FLP_OFF_STATUS, `FLP_OFF_PROT};
    endfunction

    // level scheme: level n covers top 2^(n-1) blocks, 9 and above all
    function automatic logic bp_hit(input logic [3:0] lvl, input logic [8:0] g);
        logic [8:0] blk;
        blk = (g < 9'(SMALL)) ? {4'h0, g[8:4]}
                              : g - 9'(SMALL) + 9'(`FLP_FIRST_BLOCK);
        if (lvl == 4'h0)
        begin
            bp_hit = 1'b0;
        end
        else if (lvl >= 4'h9)
        begin
            bp_hit = 1'b1;
        end
        else
        begin
            bp_hit = blk >= (9'h100 - (9'h001 << (lvl - 4'h1)));
        end
    endfunction

    flp_group_map u_map
    (
        .addr  (addr_q),
        .group (grp)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 3'h3;
            sync2_q <= 3'h3;
        end
        else
        begin
            sync1_q <= {vcc_low, hw_rst_n, wp_n};
            sync2_q <= sync1_q;
        end
    end

    assign wp_high = sync2_q[0];
    assign hw_rst  = !sync2_q[1];
    assign inhibit = sync2_q[2] || hw_rst;

    // apb slave: one wait state, effect on the edge that samples pready
    assign acc  = psel && penable;
    assign done = acc && pready_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= acc && !pready_q;
        end
    end

    assign sreg = {status_write_disable_q, qe_q, bp_q, wel_q, 1'b0};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (acc && !pready_q)
        begin
            pslverr_q <= !reg_hit(paddr);
            prdata_q  <= 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (paddr)
                    `FLP_OFF_CMD:    prdata_q <= {28'h0000000, op_q};
                    `FLP_OFF_ADDR:   prdata_q <= {8'h00, addr_q};
                    `FLP_OFF_DATA:   prdata_q <= {24'h000000, data_q};
                    `FLP_OFF_STATUS: prdata_q <= {19'h00000, wp_high, refused_q,
                                                  unlk_dis_q, pwd_mode_q, lock_q, sreg};
                    `FLP_OFF_PROT:
                    begin
                        prdata_q[`FLP_PR_GRP_PROT] <= grp_prot;
                        prdata_q[7:0] <= dyb_q[grp] ? `FLP_BYTE_UNPROT
                                                    : `FLP_BYTE_PROT;
                        prdata_q[15:8] <= ppb_q[grp] ? `FLP_BYTE_UNPROT
                                                     : `FLP_BYTE_PROT;
                    end
                    default:         prdata_q <= 32'h0000_0000;
                endcase
            end
        end
        else
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // operand registers; password readback is never offered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_q   <= 24'h000000;
            data_q   <= 8'h00;
            pwd_in_q <= 64'h0000_0000_0000_0000;
        end
        else if (done && pwrite)
        begin
            if (paddr == `FLP_OFF_ADDR)
            begin
                addr_q <= pwdata[23:0];
            end
            if (paddr == `FLP_OFF_DATA)
            begin
                data_q <= pwdata[7:0];
            end
            if (paddr == `FLP_OFF_PWD_LO)
            begin
                pwd_in_q[31:0] <= pwdata;
            end
            if (paddr == `FLP_OFF_PWD_HI)
            begin
                pwd_in_q[63:32] <= pwdata;
            end
        end
    end

    // command issue: executes the cycle after the write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_q <= FLP_OP_NOP;
            go_q <= 1'b0;
        end
        else
        begin
            go_q <= done && pwrite && (paddr == `FLP_OFF_CMD);
            if (done && pwrite && (paddr == `FLP_OFF_CMD))
            begin
                op_q <= flp_op_t'(pwdata[3:0]);
            end
        end
    end

    assign grp_prot = bp_hit(bp_q, grp) || !ppb_q[grp] || !dyb_q[grp];
    assign accept   = go_q && !inhibit && (!needs_wel(op_q) || wel_q);

    always_comb
    begin
        unique case (op_q)
            FLP_OP_WRSR:   ok = !(status_write_disable_q && !wp_high);
            FLP_OP_PROG,
            FLP_OP_ERASE:  ok = !grp_prot;
            FLP_OP_PGPPB,
            FLP_OP_ERPPB:  ok = lock_q;
            FLP_OP_WRDYB:  ok = (data_q == `FLP_BYTE_PROT)
                                || (data_q == `FLP_BYTE_UNPROT);
            FLP_OP_UNLOCK: ok = pwd_mode_q && !unlk_dis_q
                                && (pwd_in_q == pwd_q);
            FLP_OP_PGPWD:  ok = !pwd_mode_q;
            default:       ok = 1'b1;
        endcase
        ok = ok && accept;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wel_q <= 1'b0;
        end
        else if (hw_rst)
        begin
            wel_q <= 1'b0;
        end
        else if (accept)
        begin
            wel_q <= (op_q == FLP_OP_WRITE_ENABLE_COMMAND) || (!needs_wel(op_q) && wel_q
                     && (op_q != FLP_OP_WRDI));
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bp_q   <= 4'h0;
            qe_q   <= 1'b0;
            status_write_disable_q <= 1'b0;
        end
        else if (ok && (op_q == FLP_OP_WRSR))
        begin
            bp_q   <= data_q[`FLP_SR_BP_LSB +: 4];
            qe_q   <= data_q[`FLP_SR_QE];
            status_write_disable_q <= data_q[`FLP_SR_STATUS_WRITE_DISABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dyb_q <= {GROUPS{`FLP_DYB_RST}};
        end
        else if (hw_rst)
        begin
            dyb_q <= {GROUPS{`FLP_DYB_RST}};
        end
        else if (ok && (op_q == FLP_OP_WRDYB))
        begin
            dyb_q[grp] <= (data_q == `FLP_BYTE_UNPROT);
        end
    end

    // non-volatile: hardware reset leaves it; power-on or the erase command returns the delivered state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ppb_q <= {GROUPS{`FLP_PPB_RST}};
        end
        else if (ok && (op_q == FLP_OP_PGPPB))
        begin
            ppb_q[grp] <= 1'b0;
        end
        else if (ok && (op_q == FLP_OP_ERPPB))
        begin
            ppb_q <= {GROUPS{1'b1}};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwd_mode_q <= 1'b0;
        end
        else if (ok && (op_q == FLP_OP_PWDSEL))
        begin
            pwd_mode_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwd_q <= `FLP_PWD_RST;
        end
        else if (ok && (op_q == FLP_OP_PGPWD))
        begin
            pwd_q <= pwd_q & pwd_in_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_q <= `FLP_LOCK_RST;
        end
        else if (hw_rst)
        begin
            lock_q <= !pwd_mode_q;
        end
        else if (ok && (op_q == FLP_OP_CLRLK))
        begin
            lock_q <= 1'b0;
        end
        else if (ok && (op_q == FLP_OP_UNLOCK))
        begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unlk_dis_q <= 1'b0;
        end
        else if (hw_rst)
        begin
            unlk_dis_q <= 1'b0;
        end
        else if (ok && (op_q == FLP_OP_CLRLK))
        begin
            unlk_dis_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refused_q <= 1'b0;
        end
        else if (go_q)
        begin
            refused_q <= !ok;
        end
    end

    // array program/erase verdict; refused ones never reach the array
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grant_q  <= 1'b0;
            reject_q <= 1'b0;
        end
        else
        begin
            grant_q  <= go_q && (op_q inside {FLP_OP_PROG, FLP_OP_ERASE}) && ok;
            reject_q <= go_q && (op_q inside {FLP_OP_PROG, FLP_OP_ERASE}) && !ok;
        end
    end

endmodule // flp_top

// >>> flp_top_properties.sv
// port-level assertions of the flash write-protection block
// assumes binding to flp_top; one clock pclk, reset presetn
`timescale 1ns/1ps
`include "flp_map.svh"

module flp_top_properties
    import flp_pkg::*;
#(
    parameter int GROUPS = `FLP_GROUPS,
    parameter int SMALL  = `FLP_SMALL_GROUPS
)
(
    input wire logic        pclk,        // clock
    input wire logic        presetn,     // reset, low
    input wire logic        psel,        // select
    input wire logic        penable,     // enable
    input wire logic        pwrite,      // direction
    input wire logic [7:0]  paddr,       // address
    input wire logic [31:0] pwdata,      // write data
    input wire logic [31:0] prdata,      // read data
    input wire logic        pready,      // ready
    input wire logic        pslverr,     // error
    input wire logic        wp_n,        // protect pin
    input wire logic        hw_rst_n,    // reset pin
    input wire logic        vcc_low,     // supply low
    input wire logic        prog_grant,  // write granted
    input wire logic        prog_reject, // write refused
    input wire logic        lock_out     // lock level
);
    logic [3:0] op_q;   // last opcode written
    logic [2:0] age_q;  // edges since that write
    logic [2:0] hw_q;   // edges since reset pin low
    logic       acc;
    logic       cmd_w;
    assign acc   = psel && penable && pready;
    assign cmd_w = acc && pwrite && paddr == `FLP_OFF_CMD;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {op_q, age_q} <= 7'h07;
        else if (cmd_w)
            {op_q, age_q} <= {pwdata[3:0], 3'h0};
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hw_q <= 3'h7;
        else if (!hw_rst_n)
            hw_q <= 3'h0;
        else if (hw_q != 3'h7)
            hw_q <= hw_q + 3'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready ##1 !pready;
    endsequence
    a_ready_timing: assert property (s_setup |=> s_answer)
        else $error("ready not one cycle after two access cycles");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (
        acc && (paddr > `FLP_OFF_PROT || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (
        acc && paddr <= `FLP_OFF_PROT && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_pulse_excl: assert property (!(prog_grant && prog_reject))
        else $error("grant and reject together");
    a_pulse_cause: assert property (
        prog_grant || prog_reject |-> age_q == 3'h1 && op_q inside {FLP_OP_PROG, FLP_OP_ERASE})
        else $error("pulse without array command");
    a_prog_answer: assert property (
        cmd_w && hw_q == 3'h7 && pwdata[3:0] inside {FLP_OP_PROG, FLP_OP_ERASE}
        |-> ##2 prog_grant != prog_reject)
        else $error("array command without answer");
    a_lock_powerup: assert property ($rose(presetn) |-> lock_out)
        else $error("lock not set at power-up");
    a_lock_rise: assert property (
        $rose(lock_out) |-> (age_q == 3'h1 && op_q == FLP_OP_UNLOCK) || hw_q <= 3'h4)
        else $error("lock set without unlock or reset");
    a_lock_fall: assert property (
        $fell(lock_out) |-> (age_q == 3'h1 && op_q == FLP_OP_CLRLK) || hw_q <= 3'h4)
        else $error("lock cleared without clear or reset");
endmodule // flp_top_properties

bind flp_top flp_top_properties #(.GROUPS(GROUPS), .SMALL(SMALL)) u_props (.*);

// >>> flp_host_model.sv
// bus host model standing for the command-issuing controller
// assumes a rising-edge clock and a slave that answers with pready
`timescale 1ns/1ps

module flp_host_model
(
    input  wire logic        pclk,    // clock
    input  wire logic        pready,  // slave ready
    output logic             psel,    // select
    output logic             penable, // enable
    output logic             pwrite,  // direction
    output logic [7:0]       paddr,   // address
    output logic [31:0]      pwdata   // write data
);
    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // entered just after an edge; idle values scrambled once released
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        {psel, penable} <= 2'h0;
        paddr   <= ~a;
        pwdata  <= ~d;
        @(posedge pclk);
    endtask
endmodule // flp_host_model

// >>> flash_write_protection_logic_tb.sv
// self-checking bench: host model issues commands, monitor compares against queued notes
// assumes flp_top, flp_host_model and the bound checker
`timescale 1ns/1ps
`include "flp_map.svh"

module flash_write_protection_logic_tb
    import flp_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        wp_n = 1'b1;
    logic        hw_rst_n = 1'b1;
    logic        vcc_low = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, prog_grant, prog_reject, lock_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [63:0] rq[$];
    logic        gq[$];
    logic [63:0] e, pw;
    logic [23:0] al[3];
    int          n_fail = 0;
    int          n_checks = 0;
    always #4 pclk = ~pclk;
    flp_host_model host (.*);
    flp_top uut (.*);
    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        n_checks++;
        if (s !== x)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", n, x, s);
        end
    endtask
    always @(posedge pclk)
    begin
        if (presetn && psel && penable && pready)
            chk("pslverr", {31'h0, paddr > `FLP_OFF_PROT || paddr[1:0] != 2'h0},
                {31'h0, pslverr});
        if (presetn && psel && penable && pready && !pwrite)
        begin
            e = rq.pop_front();
            chk("prdata", e[31:0], prdata & e[63:32]);
            if (paddr == `FLP_OFF_STATUS && e[40])
                chk("lock_out", {31'h0, e[8]}, {31'h0, lock_out});
        end
        if (prog_grant || prog_reject)
            chk("prog_grant", {31'h0, gq.pop_front()}, {31'h0, prog_grant});
    end
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    task cmd(input flp_op_t o);
        wr(`FLP_OFF_CMD, {28'h0, o});
    endtask
    task wcmd(input flp_op_t o);
        cmd(FLP_OP_WRITE_ENABLE_COMMAND);
        cmd(o);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        rq.push_back({m, x & m});
        host.xfer(1'b0, a, 32'h0);
    endtask
    task st(input logic [31:0] m, input logic [31:0] x);
        rd(`FLP_OFF_STATUS, m, x);
    endtask
    task pr(input logic [23:0] a, input logic [31:0] x);
        wr(`FLP_OFF_ADDR, {8'h0, a});
        rd(`FLP_OFF_PROT, 32'h1FFFF, x);
    endtask
    task dynamic_protect_bit(input logic [23:0] a, input logic [7:0] v);
        wr(`FLP_OFF_ADDR, {8'h0, a});
        wr(`FLP_OFF_DATA, {24'h0, v});
        wcmd(FLP_OP_WRDYB);
    endtask
    task pg(input logic [23:0] a, input logic w, input logic g,
            input flp_op_t o = FLP_OP_PROG);
        wr(`FLP_OFF_ADDR, {8'h0, a});
        if (w)
            cmd(FLP_OP_WRITE_ENABLE_COMMAND);
        gq.push_back(g);
        cmd(o);
    endtask
    task wsr(input logic [7:0] v);
        wr(`FLP_OFF_DATA, {24'h0, v});
        wcmd(FLP_OP_WRSR);
    endtask
    task pwd(input logic [63:0] v);
        wr(`FLP_OFF_PWD_LO, v[31:0]);
        wr(`FLP_OFF_PWD_HI, v[63:32]);
    endtask
    task hold;
        repeat (4) @(posedge pclk);
    endtask
    task hwr;
        hw_rst_n <= 1'b0;
        hold();
        hw_rst_n <= 1'b1;
        hold();
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'hC9A6E4F7));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        hold();
        st(32'h702, 32'h100);
        pr(24'h000000, 32'h0FFFF);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        pg(24'h0, 1'b0, 1'b0);
        pg(24'h0, 1'b1, 1'b1);
        wr(`FLP_OFF_DATA, 32'h40);
        cmd(FLP_OP_WRSR);
        st(32'h40, 32'h0);
        vcc_low <= 1'b1;
        hold();
        pg(24'h0, 1'b1, 1'b0);
        vcc_low <= 1'b0;
        hold();
        cmd(FLP_OP_WRITE_ENABLE_COMMAND);
        st(32'h2, 32'h2);
        cmd(FLP_OP_WRDI);
        st(32'h2, 32'h0);
        pg(24'h0, 1'b0, 1'b0);
        $display("test enable done");
        for (int i = 0; i < 4; i++)
        begin
            wsr({i[1], 7'h0});
            wp_n <= i[0];
            hold();
            wsr({i[1], 7'h40});
            st(32'h40, (i == 2) ? 32'h0 : 32'h40);
            wp_n <= 1'b1;
            hold();
        end
        wsr(8'h00);
        $display("test status guard done");
        wsr(8'h04);
        pg(24'hFF0000, 1'b1, 1'b0);
        pg(24'hFE0000, 1'b1, 1'b1);
        pg(24'hFF0000, 1'b1, 1'b0, FLP_OP_ERASE);
        pg(24'hFE0000, 1'b1, 1'b1, FLP_OP_ERASE);
        dynamic_protect_bit(24'hFE0000, 8'h00);
        pg(24'hFE0000, 1'b1, 1'b0);
        dynamic_protect_bit(24'hFE0000, 8'hFF);
        wsr(8'h00);
        al = '{24'h020000 + 24'($urandom % 32'hFE0000), 24'h01F000, 24'h020000};
        for (int i = 0; i < 3; i++)
        begin
            dynamic_protect_bit(al[i], 8'h00);
            pr(al[i], 32'h1FF00);
            pr(al[i] - ((al[i] > 24'h01FFFF) ? 24'h10000 : 24'h1000), 32'h0FFFF);
            pg(al[i], 1'b1, 1'b0);
            dynamic_protect_bit(al[i], 8'hFF);
            pr(al[i], 32'h0FFFF);
        end
        $display("test sector bits done");
        wr(`FLP_OFF_ADDR, 32'h030000);
        wcmd(FLP_OP_PGPPB);
        pr(24'h030000, 32'h100FF);
        pr(24'h040000, 32'h0FFFF);
        wcmd(FLP_OP_ERPPB);
        pr(24'h030000, 32'h0FFFF);
        wcmd(FLP_OP_CLRLK);
        cmd(FLP_OP_UNLOCK);
        st(32'h100, 32'h0);
        wcmd(FLP_OP_PGPPB);
        st(32'h900, 32'h800);
        pr(24'h030000, 32'h0FFFF);
        dynamic_protect_bit(24'h050000, 8'h00);
        hwr();
        st(32'h100, 32'h100);
        pr(24'h050000, 32'h0FFFF);
        $display("test persistent done");
        pw = {$urandom, $urandom};
        pwd(pw);
        wcmd(FLP_OP_PGPWD);
        wcmd(FLP_OP_PWDSEL);
        st(32'h200, 32'h200);
        hwr();
        st(32'h100, 32'h0);
        pwd(pw ^ 64'h1);
        cmd(FLP_OP_UNLOCK);
        st(32'h100, 32'h0);
        pwd(pw);
        cmd(FLP_OP_UNLOCK);
        st(32'h100, 32'h100);
        wcmd(FLP_OP_CLRLK);
        cmd(FLP_OP_UNLOCK);
        st(32'h500, 32'h400);
        hwr();
        cmd(FLP_OP_UNLOCK);
        st(32'h500, 32'h100);
        $display("test password done");
        hold();
        final_report();
    end
endmodule // flash_write_protection_logic_tb
